// File: verilog/sfr_top.sv
// serial status readback: word select, flag latches and word assembly
//
// Notes on behaviour
// - host writes four-bit word select field
// - persist off: selection used once, then quick word
// - persist on: selection kept until reprogrammed
// - quick word layout: code 0001, globals, summaries
// - bit 11 shows fail mode in every word except the id word and the all-zero word of unused selects
// - global flags clear once all fault bits read
// - device flag ORs device-level fault flags except the serial fail flag
// - overload ORs overcurrent and shutdown flags
// - cleared-registers flag set after reset
// - channel summary ORs all channel flags
// - select zero returns the quick word
// - channel words two to six layout
// - overcurrent code keeps most recent event
// - device word seven layout
// - limp flag live, never latched
// - word eight carries live pin states
// - toggle bit ORs four input toggles
// - output states compare half battery voltage
// - id word nine, code zero under undervoltage
// - reading a channel word clears its latches
`timescale 1ns/1ps
`include "sfr_params.svh"

module sfr_top #(
	parameter logic [7:0] PART_CODE = 8'h5a // arbitrary value
) (
	// system
	input  wire logic                      CLOCK,
	input  wire logic                      RST_N,
	// serial link
	input  wire logic                      SCLK,
	input  wire logic                      CS_N,
	input  wire logic                      SI,
	output logic                           SO,
	output logic                           SO_OE,
	// detector events, same clock
	input  wire sfr_pkg::sfr_ch_evt_type [4:0] CH_EVT,
	input  wire sfr_pkg::sfr_dev_evt_type  DEV_EVT,
	input  wire logic                      FAIL_MODE,
	// live pin levels
	input  wire sfr_pkg::sfr_live_io_type  LIVE_IO
);
	import sfr_pkg::*;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic                    cs_meta;
		logic                    cs_sync;
		logic                    cs_prev;
		sfr_live_io_type         io_meta;
		sfr_live_io_type         io_sync;
		logic [3:0]              sel;
		logic                    persist;
		sfr_ch_flags_type [4:0]  ch;
		sfr_dev_flags_type       dev;
		sfr_dev_flags_type       dev_snap;
		logic [15:0]             word;
	} sfr_core_type;

	typedef struct packed {
		logic [15:0] sh;
		logic        valid;
	} sfr_link_type;

	sfr_core_type core_q;
	sfr_core_type core_d;
	sfr_link_type link_q;
	sfr_link_type link_d;
	logic [4:0]   cnt_q;
	logic         so_q;
	logic         cnt_rst_n;

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// sticky flag: a set in the clearing cycle wins
	function automatic logic sticky(input logic q, input logic set, input logic clr);
		sticky = set | (q & ~clr);
	endfunction : sticky

	function automatic logic ch_summary(input sfr_ch_flags_type f);
		ch_summary = (|f.oc) | f.otw | f.ots | f.olon | f.oloff;
	endfunction : ch_summary

	function automatic logic [15:0] ch_word(
		input logic [3:0]       code,
		input logic             fm,
		input logic [2:0]       glob,
		input sfr_ch_flags_type f
	);
		ch_word = {code, fm, glob, `SFR_RES1, f};
	endfunction : ch_word

	// ------------------------------------------------------------------------
	// global flags, all combinational over the latches
	// ------------------------------------------------------------------------
	logic       device_fault_summary;
	logic       overload_summary;
	logic       open_load_summary;
	logic [4:0] qsf;
	logic [2:0] glob;
	logic       fm;

	assign fm = FAIL_MODE;

	always_comb begin
		overload_summary = 1'b0;
		open_load_summary  = 1'b0;
		qsf  = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			overload_summary   = overload_summary | (|core_q.ch[i].oc) | core_q.ch[i].ots;
			open_load_summary    = open_load_summary | core_q.ch[i].olon | core_q.ch[i].oloff;
			qsf[i] = ch_summary(core_q.ch[i]);
		end
		device_fault_summary = core_q.dev.registers_cleared_flag | core_q.dev.undervoltage_flag | core_q.dev.ovf
			| core_q.dev.charge_pump_fault | core_q.dev.clock_fail_flag | core_q.dev.test_mode_flag;
	end

	// the globals follow the latches, so they fall only when every
	// latch behind them has been read away
	assign glob = {device_fault_summary, overload_summary, open_load_summary};

	// ------------------------------------------------------------------------
	// word assembly
	// ------------------------------------------------------------------------
	logic [15:0] word_sel;

	always_comb begin
		word_sel = `SFR_WORD_NONE;
		case (core_q.sel)
			`SFR_SEL_QUICK0,
			`SFR_SEL_QUICK: begin
				word_sel = {`SFR_SEL_QUICK, fm, glob, core_q.dev.charge_pump_fault,
					core_q.dev.registers_cleared_flag, core_q.dev.clock_fail_flag, qsf};
			end
			`SFR_SEL_DEV: begin
				// limp level is the synchronised pin, never latched
				word_sel = {`SFR_SEL_DEV, fm, glob, `SFR_RES3,
					core_q.dev.test_mode_flag, core_q.dev.ovf, core_q.dev.undervoltage_flag,
					core_q.dev.serial_fail_flag, core_q.io_sync.limp};
			end
			`SFR_SEL_IO: begin
				word_sel = {`SFR_SEL_IO, fm, `SFR_RES1,
					|core_q.io_sync.toggle, core_q.io_sync.in_state,
					core_q.io_sync.out_level};
			end
			`SFR_SEL_ID: begin
				word_sel = {`SFR_SEL_ID, `SFR_ID_FILL,
					core_q.dev.undervoltage_flag ? `SFR_UV_PART_CODE : PART_CODE};
			end
			default: begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (core_q.sel == `SFR_SEL_CH1 + 4'(i)) begin
						word_sel = ch_word(core_q.sel, fm, glob, core_q.ch[i]);
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// core domain
	// ------------------------------------------------------------------------
	logic             frame_end;
	logic             rd_ok;
	logic             clr_ch;
	logic             clr_dev;
	sfr_ch_flags_type rep;
	sfr_dev_flags_type snap;
	logic [3:0]       rx_addr;

	assign frame_end = ~core_q.cs_prev & core_q.cs_sync;
	assign rd_ok     = frame_end & link_q.valid;
	assign rep       = core_q.word[`SFR_FLAG_HI:`SFR_FLAG_LO];
	assign snap      = core_q.dev_snap;
	assign rx_addr   = link_q.sh[`SFR_RX_ADDR_HI:`SFR_RX_ADDR_LO];
	assign clr_dev   = rd_ok & (core_q.sel == `SFR_SEL_DEV);

	always_comb begin
		core_d = core_q;
		clr_ch = 1'b0;
		// only the synchronised copy feeds the edge detector
		core_d.cs_meta = CS_N;
		core_d.cs_sync = core_q.cs_meta;
		core_d.cs_prev = core_q.cs_sync;
		core_d.io_meta = LIVE_IO;
		core_d.io_sync = core_q.io_meta;

		// channel latches: only what the frame reported is cleared, so an
		// event that lands after the snapshot survives the read
		for (int i = 0; i < NUM_CH; i++) begin
			clr_ch = rd_ok & (core_q.sel == `SFR_SEL_CH1 + 4'(i));
			core_d.ch[i].ots = sticky(core_q.ch[i].ots, CH_EVT[i].ots,
				clr_ch & rep.ots);
			core_d.ch[i].otw = sticky(core_q.ch[i].otw, CH_EVT[i].otw,
				clr_ch & rep.otw);
			core_d.ch[i].olon = sticky(core_q.ch[i].olon, CH_EVT[i].olon,
				clr_ch & rep.olon);
			core_d.ch[i].oloff = sticky(core_q.ch[i].oloff, CH_EVT[i].oloff,
				clr_ch & rep.oloff);
			if (CH_EVT[i].oc_evt) begin
				core_d.ch[i].oc = CH_EVT[i].oc_code;
			end else if (clr_ch && core_q.ch[i].oc == rep.oc) begin
				core_d.ch[i].oc = `SFR_OC_NONE;
			end
		end

		// device latches, cleared by reading word seven
		core_d.dev.registers_cleared_flag  = sticky(core_q.dev.registers_cleared_flag, 1'b0, clr_dev & snap.registers_cleared_flag);
		core_d.dev.charge_pump_fault  = sticky(core_q.dev.charge_pump_fault, DEV_EVT.charge_pump_fault, clr_dev & snap.charge_pump_fault);
		core_d.dev.clock_fail_flag = sticky(core_q.dev.clock_fail_flag, DEV_EVT.clock_fail_flag, clr_dev & snap.clock_fail_flag);
		core_d.dev.test_mode_flag  = sticky(core_q.dev.test_mode_flag, DEV_EVT.test_mode_flag, clr_dev & snap.test_mode_flag);
		core_d.dev.ovf  = sticky(core_q.dev.ovf, DEV_EVT.ovf, clr_dev & snap.ovf);
		core_d.dev.undervoltage_flag  = sticky(core_q.dev.undervoltage_flag, DEV_EVT.undervoltage_flag, clr_dev & snap.undervoltage_flag);
		// a frame of the wrong length also counts as a serial fault
		core_d.dev.serial_fail_flag = sticky(core_q.dev.serial_fail_flag,
			DEV_EVT.serial_fail_flag | (frame_end & ~link_q.valid), clr_dev & snap.serial_fail_flag);

		// selection update once per complete frame
		if (rd_ok) begin
			if (rx_addr == `SFR_ADDR_INIT) begin
				core_d.sel     = link_q.sh[`SFR_RX_SEL_HI:`SFR_RX_SEL_LO];
				core_d.persist = link_q.sh[`SFR_RX_PERSIST];
			end else if (!core_q.persist) begin
				core_d.sel = `SFR_SEL_QUICK0;
			end
			// persist set: selection left alone
		end

		// snapshot follows the flags while idle and freezes for the frame,
		// which is what lets the link side read it without a handshake
		if (core_q.cs_sync) begin
			core_d.word     = word_sel;
			core_d.dev_snap = core_q.dev;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			core_q          <= '0;
			core_q.cs_meta  <= 1'b1;
			core_q.cs_sync  <= 1'b1;
			core_q.cs_prev  <= 1'b1;
			core_q.sel      <= `SFR_SEL_RESET;
			core_q.dev.registers_cleared_flag  <= 1'b1;
		end else begin
			core_q <= core_d;
		end
	end

	// ------------------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------------------
	// the counter is held clear by the frame select itself, since the link
	// clock stands still between frames
	assign cnt_rst_n = RST_N & ~CS_N;

	always_comb begin
		link_d    = link_q;
		link_d.sh = {(cnt_q == `SFR_CNT_ZERO) ? core_q.word[14:0] : link_q.sh[14:0], SI};
		// only an exact sixteen-edge frame is valid
		link_d.valid = (cnt_q == `SFR_CNT_LAST);
	end

	always_ff @(posedge SCLK or negedge RST_N) begin
		if (!RST_N) begin
			link_q <= '0;
		end else begin
			link_q <= link_d;
		end
	end

	always_ff @(posedge SCLK or negedge cnt_rst_n) begin
		if (!cnt_rst_n) begin
			cnt_q <= `SFR_CNT_ZERO;
		end else if (cnt_q != `SFR_CNT_OVER) begin
			cnt_q <= cnt_q + `SFR_CNT_ONE;
		end
	end

	// output changes on the falling edge so the host samples on the rising
	always_ff @(negedge SCLK or negedge RST_N) begin
		if (!RST_N) begin
			so_q <= 1'b0;
		end else begin
			so_q <= link_q.sh[`SFR_WORD_MSB];
		end
	end

	// msb is presented from the snapshot before the first edge
	assign SO    = (cnt_q == `SFR_CNT_ZERO) ? core_q.word[`SFR_WORD_MSB] : so_q;
	assign SO_OE = ~CS_N;

endmodule : sfr_top

// File: verilog/sfr_params.svh
// constants for the status readback block
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH
// ----------------------------------------------------------------------------
// word select codes, which double as the address code of each word except select zero
// ----------------------------------------------------------------------------
`define SFR_SEL_QUICK0    4'h0
`define SFR_SEL_QUICK     4'h1
`define SFR_SEL_CH1       4'h2
`define SFR_SEL_DEV       4'h7
`define SFR_SEL_IO        4'h8
`define SFR_SEL_ID        4'h9
`define SFR_SEL_RESET     4'h0
// ----------------------------------------------------------------------------
// received frame layout
// ----------------------------------------------------------------------------
`define SFR_ADDR_INIT     4'h0
`define SFR_RX_ADDR_HI    15
`define SFR_RX_ADDR_LO    12
`define SFR_RX_PERSIST    4
`define SFR_RX_SEL_HI     3
`define SFR_RX_SEL_LO     0
// ----------------------------------------------------------------------------
// word fields and fixed values
// ----------------------------------------------------------------------------
`define SFR_WORD_MSB      15
`define SFR_FLAG_HI       6
`define SFR_FLAG_LO       0
`define SFR_RES1          1'b0
`define SFR_RES3          3'h0
`define SFR_ID_FILL       4'h0
`define SFR_UV_PART_CODE  8'h00
`define SFR_WORD_NONE     16'h0000
`define SFR_OC_NONE       3'h0
// ----------------------------------------------------------------------------
// frame bit counter
// ----------------------------------------------------------------------------
`define SFR_CNT_ZERO      5'd0
`define SFR_CNT_LAST      5'd15
`define SFR_CNT_OVER      5'd17
`define SFR_CNT_ONE       5'd1
`endif

// File: verilog/sfr_pkg.sv
// types shared by the status readback block
package sfr_pkg;
	localparam int NUM_CH = 5;

	typedef struct packed {
		logic       ots;
		logic       otw;
		logic       olon;
		logic       oloff;
		logic       oc_evt;
		logic [2:0] oc_code;
	} sfr_ch_evt_type;

	// bit order matches bits 6..0 of a channel word
	typedef struct packed {
		logic       ots;
		logic       otw;
		logic [2:0] oc;
		logic       olon;
		logic       oloff;
	} sfr_ch_flags_type;

	typedef struct packed {
		logic charge_pump_fault;
		logic clock_fail_flag;
		logic undervoltage_flag;
		logic ovf;
		logic test_mode_flag;
		logic serial_fail_flag;
	} sfr_dev_evt_type;

	typedef struct packed {
		logic registers_cleared_flag;
		logic charge_pump_fault;
		logic clock_fail_flag;
		logic test_mode_flag;
		logic ovf;
		logic undervoltage_flag;
		logic serial_fail_flag;
	} sfr_dev_flags_type;

	typedef struct packed {
		logic       limp;
		logic [3:0] in_state;
		logic [3:0] toggle;
		logic [4:0] out_level;
	} sfr_live_io_type;
endpackage : sfr_pkg

// File: tb/sfr_top_checker.sv
// concurrent checks on the readback ports, bound into sfr_top
`timescale 1ns/1ps

module sfr_top_checker
	import sfr_pkg::*;
#(
	parameter logic [7:0] PART_CODE = 8'h5a
) (
	// system
	input wire logic            CLOCK,
	input wire logic            RST_N,
	// serial link
	input wire logic            SCLK,
	input wire logic            CS_N,
	input wire logic            SO,
	input wire logic            SO_OE,
	// status sources
	input wire logic            FAIL_MODE,
	input wire sfr_live_io_type LIVE_IO
);
	logic [4:0]  cnt_q;
	logic [15:0] word_q;
	logic [3:0]  addr;

	assign addr = word_q[15:12];

	// ------------------------------------------------------------
	// rebuild the word seen on the wire, one bit per rising edge
	// ------------------------------------------------------------
	always_ff @(posedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			cnt_q  <= 5'h0;
			word_q <= 16'h0;
		end else begin
			cnt_q  <= cnt_q + 5'h1;
			word_q <= {word_q[14:0], SO};
		end
	end

	sequence s_word_at(logic [3:0] a);
		cnt_q == 5'h10 && addr == a;
	endsequence

	a_oe_follows_cs: assert property (@(posedge CLOCK) disable iff (!RST_N) SO_OE == !CS_N)
		else $error("output enable does not follow select");
	a_addr_legal: assert property (@(negedge SCLK) disable iff (!RST_N)
		cnt_q == 5'h10 |-> (addr >= 4'h1 && addr <= 4'h9) || word_q == 16'h0)
		else $error("illegal address code");
	a_fail_bit: assert property (@(negedge SCLK) disable iff (!RST_N)
		cnt_q == 5'h10 && addr != 4'h9 && addr != 4'h0 |-> word_q[11] == FAIL_MODE)
		else $error("fail mode bit wrong");
	a_chan_reserved: assert property (@(negedge SCLK) disable iff (!RST_N)
		cnt_q == 5'h10 && addr >= 4'h2 && addr <= 4'h6 |-> !word_q[7])
		else $error("channel reserved bit set");
	a_dev_reserved: assert property (@(negedge SCLK) disable iff (!RST_N)
		s_word_at(4'h7) |-> word_q[7:5] == 3'h0)
		else $error("device reserved bits set");
	a_limp_live: assert property (@(negedge SCLK) disable iff (!RST_N)
		s_word_at(4'h7) |-> word_q[0] == LIVE_IO.limp)
		else $error("limp bit not live");
	a_io_word: assert property (@(negedge SCLK) disable iff (!RST_N)
		s_word_at(4'h8) |-> word_q[10:0] == {1'b0, |LIVE_IO.toggle, LIVE_IO.in_state, LIVE_IO.out_level})
		else $error("io word wrong");
	a_id_word: assert property (@(negedge SCLK) disable iff (!RST_N)
		s_word_at(4'h9) |-> word_q[11:8] == 4'h0 && (word_q[7:0] == PART_CODE || word_q[7:0] == 8'h0))
		else $error("id word wrong");
	a_dsf_summary: assert property (@(negedge SCLK) disable iff (!RST_N)
		s_word_at(4'h1) |-> !(|word_q[7:5]) || word_q[10])
		else $error("device flag misses a source");
endmodule : sfr_top_checker

bind sfr_top sfr_top_checker #(.PART_CODE(PART_CODE)) u_checker (.CLOCK(CLOCK), .RST_N(RST_N), .SCLK(SCLK),
	.CS_N(CS_N), .SO(SO), .SO_OE(SO_OE), .FAIL_MODE(FAIL_MODE), .LIVE_IO(LIVE_IO));

// File: tb/sfr_host_model.sv
// host side serial master driving frames into the readback block
`timescale 1ns/1ps

module sfr_host_model (
	// serial link
	output logic      SCLK,
	output logic      CS_N,
	output logic      SI,
	input  wire logic SO
);
	logic [15:0] rx_word;
	logic        full;
	event        frame_done;

	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		SI   = 1'b0;
		full = 1'b0;
	end

	// link clock of 30 ns runs only inside a frame; si is scrambled after the frame
	task automatic frame(input logic [15:0] tx, input int nbits);
		CS_N = 1'b0;
		#90;
		for (int i = 0; i < nbits; i++) begin
			SI = tx[15 - i];
			#15;
			rx_word = {rx_word[14:0], SO};
			SCLK    = 1'b1;
			#15;
			SCLK = 1'b0;
		end
		#30;
		SI   = ~SI;
		CS_N = 1'b1;
		full = (nbits == 16);
		#200;
		->frame_done;
	endtask : frame
endmodule : sfr_host_model

// File: tb/spi_fault_status_readback_tb.sv
// self-checking bench for the serial status readback block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end

module spi_fault_status_readback_tb;
	import sfr_pkg::*;
	localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary value

	logic                  clock;
	logic                  rst_n;
	logic                  fail_mode;
	sfr_ch_evt_type [4:0]  ch_evt;
	sfr_dev_evt_type       dev_evt;
	sfr_live_io_type       live_io;
	wire logic             sclk;
	wire logic             cs_n;
	wire logic             si;
	wire logic             so;
	int                    num_errors = 0;
	int                    check_count = 0;
	logic [15:0]           exp_q[$];
	logic [15:0]           e;
	logic [15:0]           io_w;
	logic [31:0]           rnd = 32'h897cbb48;
	logic [2:0]            c2;

	sfr_top #(.PART_CODE(ID_CODE)) uut (.CLOCK(clock), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SI(si),
		.SO(so), .SO_OE(), .CH_EVT(ch_evt), .DEV_EVT(dev_evt), .FAIL_MODE(fail_mode), .LIVE_IO(live_io));
	sfr_host_model host (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic wrap_up;
		if (exp_q.size() != 0) num_errors++;
		if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic rd(input logic [15:0] tx, input logic [15:0] ex);
		exp_q.push_back(ex);
		host.frame(tx, 16);
	endtask : rd

	// overtemp shutdown plus an overcurrent code on channel 3
	task automatic pulse_ch(input logic [2:0] code);
		@(posedge clock) ch_evt[2] <= {5'b10001, code};
		@(posedge clock) ch_evt <= '0;
		repeat (8) @(posedge clock);
	endtask : pulse_ch

	always @(host.frame_done) begin
		if (host.full) begin
			e = exp_q.pop_front();
			`CHK(host.rx_word, e)
		end
	end

	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end

	initial begin
		rst_n     = 1'b0;
		fail_mode = 1'b0;
		ch_evt    = '0;
		dev_evt   = '0;
		live_io   = {1'b1, 13'h0};
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		host.frame(16'h8000, 8);
		rd(16'h8000, 16'h1440);
		rd(16'h0007, 16'h1440);
		rd(16'h8000, 16'h7403);
		rd(16'h8000, 16'h1000);
		rnd = xs(rnd);
		pulse_ch(3'd1 + 3'(rnd % 32'd6));
		rnd = xs(rnd);
		c2  = 3'd1 + 3'(rnd % 32'd6);
		pulse_ch(c2);
		rd(16'h8000, 16'h1204);
		rd(16'h0014, 16'h1204);
		rd(16'h8000, 16'h4240 | {11'h0, c2, 2'b0});
		rd(16'h8000, 16'h4000);
		rnd = xs(rnd);
		@(posedge clock);
		fail_mode <= 1'b1;
		live_io   <= {1'b1, rnd[12:0]};
		repeat (8) @(posedge clock);
		io_w = {5'h11, 1'b0, |rnd[8:5], rnd[12:9], rnd[4:0]};
		rd(16'h0018, 16'h4800);
		rd(16'h8000, io_w);
		rd(16'h0019, io_w);
		rd(16'h8000, {8'h90, ID_CODE});
		@(posedge clock) dev_evt.undervoltage_flag <= 1'b1;
		@(posedge clock) dev_evt <= '0;
		repeat (8) @(posedge clock);
		rd(16'h8000, 16'h9000);
		rd(16'h0000, 16'h9000);
		rd(16'h8000, 16'h1c00);
		// device-level sources other than undervoltage and serial fail feed the summary too
		@(posedge clock) dev_evt <= 6'b110110;
		@(posedge clock) dev_evt <= '0;
		repeat (8) @(posedge clock);
		rd(16'h8000, 16'h1ca0);
		rd(16'h0007, 16'h1ca0);
		rd(16'h8000, 16'h7c1d);
		// the bench resets the device in mid-run: the host sees the cleared-registers flag again
		@(posedge clock) rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		rd(16'h8000, 16'h1c40);
		#1;
		wrap_up();
	end
endmodule : spi_fault_status_readback_tb
